/* core/css_map.vh */
// Purpose: Constants of the camera shutter sequencer: map, fields, times.
// Assumes: AXI4-Lite with 32-bit data; every register is one aligned word.
// Notes:   Times are given in milliseconds; tick counts derive from them.
`ifndef CSS_MAP_VH
`define CSS_MAP_VH

// Clock and time base.
`define CSS_CLK_KHZ      40000
`define CSS_TICK_MS      100
`define CSS_FIRST_MS     1000
`define CSS_FOCUS_MS     300
`define CSS_PAUSE_MS     100
`define CSS_MPULSE_MS    200
`define CSS_MMIN_MS      500
`define CSS_PAUSED_MS    1000

// Register byte offsets.
`define CSS_OFS_CTRL     8'h00
`define CSS_OFS_SLOT     8'h04
`define CSS_OFS_STAT     8'h08
`define CSS_OFS_TIME     8'h0C
`define CSS_OFS_PARAM    8'h10
`define CSS_OFS_PEND     8'h50
`define CSS_OFS_MODE     8'h50

// Control register bits.
`define CSS_C_START      0
`define CSS_C_MULTI      1
`define CSS_C_STOP       2
`define CSS_C_PAUSE      3
`define CSS_C_CONT       4
`define CSS_C_DITH       8
`define CSS_C_EXT        9

// Slot parameter word order within one slot.
`define CSS_P_SHOTS      2'h0
`define CSS_P_WAIT       2'h1
`define CSS_P_MLU        2'h2
`define CSS_P_EXPO       2'h3

// Slot modes.
`define CSS_M_NONE       2'h0
`define CSS_M_SINGLE     2'h1
`define CSS_M_ALL        2'h2

// Reported phase and line codes.
`define CSS_PH_IDLE      2'h0
`define CSS_PH_WAIT      2'h1
`define CSS_PH_MLU       2'h2
`define CSS_PH_EXPO      2'h3
`define CSS_LN_NONE      2'h0
`define CSS_LN_FOCUS     2'h1
`define CSS_LN_BOTH      2'h3

// Parameter reset values in ticks or shots.
`define CSS_RST_SHOTS    16'h0001
`define CSS_RST_WAIT     16'h0005
`define CSS_RST_MLU      16'h0000
`define CSS_RST_EXPO     16'h0001

// Bus responses.
`define CSS_OKAY         2'h0
`define CSS_SLVERR       2'h2

`endif

/* core/css_tick.v */
// Purpose: Divides the system clock down to the 0.1 second phase tick.
// Assumes: Clear restarts the count so a phase gets whole ticks.
// Notes:   Period is a parameter so a simulation can shorten it.
`timescale 1ns/1ps
`default_nettype none

module css_tick #(
	parameter integer CYCLES = 4000000
) (
	// Clock and reset.
	input  wire        aclk,
	input  wire        aresetn,
	// Control and tick.
	input  wire        clr,
	output wire        tick
);

	reg [31:0] cnt_r;

	// The tick fires on the last count of each period.
	assign tick = (cnt_r == CYCLES - 1);

	// Counter restarts on clear, so phase entry aligns the tick grid.
	always @(posedge aclk) begin
		if (!aresetn || clr || tick)
			cnt_r <= 32'h0;
		else
			cnt_r <= cnt_r + 32'h1;
	end

endmodule // css_tick

`default_nettype wire

/* core/css_next_slot.v */
// Purpose: Finds the next eligible program slot in rotation order.
// Assumes: Search begins at base and wraps; base itself is tried first.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none

module css_next_slot #(
	parameter integer NSLOT = 4,
	parameter integer SW    = 2
) (
	// Search start and candidates.
	input  wire [SW-1:0]    base,
	input  wire [NSLOT-1:0] elig,
	// Result.
	output reg              found,
	output reg  [SW-1:0]    idx
);

	integer  k;
	reg [SW-1:0] j;

	// Walk backwards so the nearest slot from base onward wins.
	always @* begin
		found = 1'b0;
		idx   = base;
		j     = base;
		for (k = NSLOT - 1; k >= 0; k = k - 1) begin
			j = base + k[SW-1:0];
			if (elig[j]) begin
				found = 1'b1;
				idx   = j;
			end
		end
	end

endmodule // css_next_slot

`default_nettype wire

/* core/css_top.v */
// Purpose: Camera shutter sequencer with AXI4-Lite registers.
// Assumes: Open-collector lines; an enable low means the line is pulled.
// Notes:   Function
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "css_map.vh"

module css_top #(
	parameter integer TICK_CYCLES = `CSS_TICK_MS * `CSS_CLK_KHZ,
	parameter integer NSLOT       = 4,
	parameter integer TW          = 16
) (
	// Clock and reset.
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address and data.
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response.
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read.
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Dithering mover.
	output reg         dith_req,
	input  wire        dith_done,
	input  wire        dith_busy,
	// Shutter lines, open collector.
	output reg         focus_oen,
	output reg         shutter_oen
);

	// Tick counts derived from the millisecond constants.
	localparam [TW-1:0] T_FIRST  = `CSS_FIRST_MS / `CSS_TICK_MS;
	localparam [TW-1:0] T_FOCUS  = `CSS_FOCUS_MS / `CSS_TICK_MS;
	localparam [TW-1:0] T_PAUSE  = `CSS_PAUSE_MS / `CSS_TICK_MS;
	localparam [TW-1:0] T_MPULSE = `CSS_MPULSE_MS / `CSS_TICK_MS;
	localparam [TW-1:0] T_MMIN   = `CSS_MMIN_MS / `CSS_TICK_MS;
	localparam [TW-1:0] T_PAUSED = `CSS_PAUSED_MS / `CSS_TICK_MS;

	// Sequencer states.
	localparam [3:0] ST_IDLE   = 4'h0;
	localparam [3:0] ST_DITH   = 4'h1;
	localparam [3:0] ST_WAIT   = 4'h2;
	localparam [3:0] ST_PAUSE  = 4'h3;
	localparam [3:0] ST_MPULSE = 4'h4;
	localparam [3:0] ST_MIDLE  = 4'h5;
	localparam [3:0] ST_EXPO   = 4'h6;
	localparam [3:0] ST_NEXT   = 4'h7;

	reg [3:0]    st_r;
	reg [TW-1:0] rem_r;
	reg [TW-1:0] mtot_r;
	reg [1:0]    act_r;
	reg          multi_r;
	reg          ppend_r;
	reg          tclr_r;
	reg          dith_en_r;
	reg          ext_r;
	reg [TW-1:0] pm_r [0:4*NSLOT-1];
	reg [9:0]    done_r [0:NSLOT-1];
	reg [2*NSLOT-1:0] mode_r;
	reg [7:0]    wa_r;
	reg          wr_ref_r;

	wire         tick;
	wire         run = (st_r != ST_IDLE);
	wire         paused = (st_r == ST_PAUSE);
	wire [NSLOT-1:0] elig;
	wire [NSLOT-1:0] elig_st;
	wire         nx_found;
	wire [1:0]   nx_idx;

	// Active slot parameters.
	wire [TW-1:0] p_shots = pm_r[{act_r, `CSS_P_SHOTS}];
	wire [TW-1:0] p_wait  = pm_r[{act_r, `CSS_P_WAIT}];
	wire [TW-1:0] p_mlu   = pm_r[{act_r, `CSS_P_MLU}];
	wire [TW-1:0] p_expo  = pm_r[{act_r, `CSS_P_EXPO}];
	wire [1:0]    p_mode  = mode_r[2*act_r +: 2];

	// Phase timer runs on the shared tick; the clear cycle is skipped.
	css_tick #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (tclr_r),
		.tick    (tick)
	);

	wire step = tick && !tclr_r;
	wire t_end = step && (rem_r == {{(TW-1){1'b0}}, 1'b1});

	// A slot is eligible while used and short of its shot count.
	genvar g;
	generate
		for (g = 0; g < NSLOT; g = g + 1) begin : g_elig
			assign elig[g] = (mode_r[2*g +: 2] != `CSS_M_NONE) &&
				({6'h0, done_r[g]} < pm_r[4*g]);
			// A multi start clears the counters, so only use and a nonzero shot count matter then.
			assign elig_st[g] = (mode_r[2*g +: 2] != `CSS_M_NONE) &&
				(pm_r[4*g] != {TW{1'b0}});
		end
	endgenerate

	// Search starts at the active slot at launch, else one past it.
	css_next_slot #(
		.NSLOT (NSLOT),
		.SW    (2)
	) u_next (
		.base  (run ? act_r + 2'h1 : act_r),
		.elig  (run ? elig : elig_st),
		.found (nx_found),
		.idx   (nx_idx)
	);

	// Bus write path: address and data are taken together in one beat.
	wire wr_go = s_axi_awready;
	wire [7:0] wadr = wa_r;
	wire wr_ctrl  = wr_go && (wadr == `CSS_OFS_CTRL);
	wire wr_slot  = wr_go && (wadr == `CSS_OFS_SLOT);
	wire wr_mode  = wr_go && (wadr == `CSS_OFS_MODE);
	wire wr_param = wr_go && (wadr >= `CSS_OFS_PARAM) &&
		(wadr < `CSS_OFS_MODE) && (wadr[1:0] == 2'h0);
	wire [3:0] pidx = wadr[5:2] - 4'h4;
	wire par_ok = !run || paused;
	wire slot_ok = !run;
	wire [15:0] wmrg_old = pm_r[pidx];
	wire [15:0] wmrg = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : wmrg_old[15:8],
		s_axi_wstrb[0] ? s_axi_wdata[7:0] : wmrg_old[7:0]};
	wire cmd_lane = s_axi_wstrb[0];
	wire c_start = wr_ctrl && cmd_lane && s_axi_wdata[`CSS_C_START];
	wire c_multi = wr_ctrl && cmd_lane && s_axi_wdata[`CSS_C_MULTI];
	wire c_stop  = wr_ctrl && cmd_lane && s_axi_wdata[`CSS_C_STOP];
	wire c_pause = wr_ctrl && cmd_lane && s_axi_wdata[`CSS_C_PAUSE];
	wire c_cont  = wr_ctrl && cmd_lane && s_axi_wdata[`CSS_C_CONT];
	wire wr_known = wr_ctrl || wr_slot || wr_mode || wr_param;
	wire wr_bad = !wr_known || (wr_param && !par_ok) ||
		(wr_slot && !slot_ok);

	// Write channel handshake and response; one write in flight.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `CSS_OKAY;
			wa_r          <= 8'h00;
			wr_ref_r      <= 1'b0;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			wa_r <= s_axi_awaddr;
			if (!s_axi_awready && !s_axi_bvalid &&
				s_axi_awvalid && s_axi_wvalid) begin
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_bad ? `CSS_SLVERR : `CSS_OKAY;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			wr_ref_r <= wr_go && wr_bad;
		end
	end

	// Parameter storage; refused writes leave the slot untouched.
	integer i;
	always @(posedge aclk) begin
		if (!aresetn) begin
			for (i = 0; i < NSLOT; i = i + 1) begin
				pm_r[4*i]     <= `CSS_RST_SHOTS;
				pm_r[4*i + 1] <= `CSS_RST_WAIT;
				pm_r[4*i + 2] <= `CSS_RST_MLU;
				pm_r[4*i + 3] <= `CSS_RST_EXPO;
			end
			mode_r    <= {(2*NSLOT){1'b0}};
			dith_en_r <= 1'b0;
			ext_r     <= 1'b0;
		end else begin
			if (wr_param && par_ok)
				pm_r[pidx] <= wmrg;
			if (wr_mode && cmd_lane)
				mode_r <= s_axi_wdata[2*NSLOT-1:0];
			if (wr_ctrl && s_axi_wstrb[1]) begin
				dith_en_r <= s_axi_wdata[`CSS_C_DITH];
				ext_r     <= s_axi_wdata[`CSS_C_EXT];
			end
		end
	end

	// Reported phase and line state.
	reg [1:0] ph;
	reg       f_on;
	reg       s_on;
	always @* begin
		ph = `CSS_PH_IDLE;
		case (st_r)
			ST_DITH, ST_WAIT, ST_PAUSE: ph = `CSS_PH_WAIT;
			ST_MPULSE, ST_MIDLE: ph = `CSS_PH_MLU;
			ST_EXPO: ph = `CSS_PH_EXPO;
			default: ph = `CSS_PH_IDLE;
		endcase
		f_on = ((st_r == ST_WAIT) && !ext_r && (rem_r <= T_FOCUS)) ||
			(st_r == ST_MPULSE) || (st_r == ST_EXPO);
		s_on = (st_r == ST_MPULSE) || (st_r == ST_EXPO) ||
			(ext_r && run && dith_busy);
	end

	wire [1:0] ln = s_on ? `CSS_LN_BOTH :
		(f_on ? `CSS_LN_FOCUS : `CSS_LN_NONE);

	// Bus read path, answered one cycle after the address is taken.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `CSS_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
				s_axi_arvalid;
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `CSS_OKAY;
				s_axi_rdata  <= 32'h0;
				if (s_axi_araddr == `CSS_OFS_CTRL)
					s_axi_rdata <= {22'h0, ext_r, dith_en_r, 8'h0};
				else if (s_axi_araddr == `CSS_OFS_SLOT)
					s_axi_rdata <= {30'h0, act_r};
				else if (s_axi_araddr == `CSS_OFS_STAT)
					s_axi_rdata <= {done_r[act_r], 13'h0, wr_ref_r,
						multi_r, ppend_r, paused, run, ln, ph};
				else if (s_axi_araddr == `CSS_OFS_TIME)
					s_axi_rdata <= {16'h0, rem_r};
				else if (s_axi_araddr == `CSS_OFS_MODE)
					s_axi_rdata <= {{(32-2*NSLOT){1'b0}}, mode_r};
				else if ((s_axi_araddr > `CSS_OFS_TIME) &&
					(s_axi_araddr < `CSS_OFS_MODE) &&
					(s_axi_araddr[1:0] == 2'h0))
					s_axi_rdata <= {16'h0,
						pm_r[s_axi_araddr[5:2] - 4'h4]};
				else
					s_axi_rresp <= `CSS_SLVERR;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Lockup total is the programmed time but never under the minimum.
	wire [TW-1:0] mlu_tot = (p_mlu < T_MMIN) ? T_MMIN : p_mlu;
	wire [TW-1:0] wait_t = ext_r ? p_expo : p_wait;
	wire          nx_stay = (p_mode == `CSS_M_ALL) && elig[act_r];
	// The run ends here when no slot is left, so no move is asked then.
	wire          nx_end = multi_r ? (!nx_stay && !nx_found) :
		(done_r[act_r] >= p_shots[9:0]);

	// Main sequencer.
	always @(posedge aclk) begin
		if (!aresetn) begin
			st_r     <= ST_IDLE;
			rem_r    <= {TW{1'b0}};
			mtot_r   <= {TW{1'b0}};
			act_r    <= 2'h0;
			multi_r  <= 1'b0;
			ppend_r  <= 1'b0;
			tclr_r   <= 1'b0;
			dith_req <= 1'b0;
			for (i = 0; i < NSLOT; i = i + 1)
				done_r[i] <= 10'h0;
		end else begin
			tclr_r   <= 1'b0;
			dith_req <= 1'b0;
			if (step)
				rem_r <= rem_r - {{(TW-1){1'b0}}, 1'b1};
			if (c_pause && run)
				ppend_r <= 1'b1;
			if (c_cont && !paused)
				ppend_r <= 1'b0;
			if (wr_slot && slot_ok)
				act_r <= s_axi_wdata[1:0];
			if (c_stop) begin
				st_r    <= ST_IDLE;
				ppend_r <= 1'b0;
				multi_r <= 1'b0;
			end else begin
				case (st_r)
					ST_IDLE: begin
						if (c_multi && !ext_r) begin
							for (i = 0; i < NSLOT; i = i + 1)
								done_r[i] <= 10'h0;
							if (|elig_st) begin
								act_r   <= nx_idx;
								multi_r <= 1'b1;
								st_r    <= ST_WAIT;
								rem_r   <= T_FIRST;
								tclr_r  <= 1'b1;
							end
						end else if (c_start || c_multi) begin
							// External timer mode falls back to a single run of the active slot.
							done_r[act_r] <= 10'h0;
							multi_r <= 1'b0;
							st_r    <= ST_WAIT;
							rem_r   <= T_FIRST;
							tclr_r  <= 1'b1;
						end
					end
					ST_DITH: begin
						// Wait is extended until the mover settles.
						if (dith_done) begin
							st_r   <= ST_WAIT;
							rem_r  <= wait_t;
							tclr_r <= 1'b1;
						end
					end
					ST_WAIT: begin
						if (ppend_r && rem_r <= T_PAUSE) begin
							st_r    <= ST_PAUSE;
							ppend_r <= 1'b0;
							rem_r   <= T_PAUSED;
						end else if (t_end) begin
							if (ext_r) begin
								done_r[act_r] <= done_r[act_r] + 10'h1;
								st_r <= ST_NEXT;
							end else if (p_mlu != {TW{1'b0}}) begin
								st_r   <= ST_MPULSE;
								rem_r  <= mlu_tot;
								mtot_r <= mlu_tot;
								tclr_r <= 1'b1;
							end else begin
								st_r   <= ST_EXPO;
								rem_r  <= p_expo;
								tclr_r <= 1'b1;
							end
						end
					end
					ST_PAUSE: begin
						rem_r <= T_PAUSED;
						if (c_cont) begin
							tclr_r <= 1'b1;
							if (ext_r) begin
								done_r[act_r] <= done_r[act_r] + 10'h1;
								st_r <= ST_NEXT;
							end else if (p_mlu != {TW{1'b0}}) begin
								st_r   <= ST_MPULSE;
								rem_r  <= mlu_tot;
								mtot_r <= mlu_tot;
							end else begin
								st_r  <= ST_EXPO;
								rem_r <= p_expo;
							end
						end
					end
					ST_MPULSE: begin
						// Mirror flip pulse, then release until exposure.
						if (step && (rem_r == mtot_r - T_MPULSE + 16'h1))
							st_r <= ST_MIDLE;
					end
					ST_MIDLE: begin
						if (t_end) begin
							st_r   <= ST_EXPO;
							rem_r  <= p_expo;
							tclr_r <= 1'b1;
						end
					end
					ST_EXPO: begin
						if (t_end) begin
							done_r[act_r] <= done_r[act_r] + 10'h1;
							st_r <= ST_NEXT;
						end
					end
					ST_NEXT: begin
						// Counters are already updated when the next slot is chosen.
						if (!multi_r) begin
							if (done_r[act_r] >= p_shots[9:0])
								st_r <= ST_IDLE;
							else
								st_r <= ST_DITH;
						end else if (p_mode == `CSS_M_ALL && elig[act_r])
							st_r <= ST_DITH;
						else if (nx_found) begin
							act_r <= nx_idx;
							st_r  <= ST_DITH;
						end else begin
							st_r    <= ST_IDLE;
							multi_r <= 1'b0;
						end
						if (!nx_end && !dith_en_r) begin
							st_r   <= ST_WAIT;
							rem_r  <= wait_t;
							tclr_r <= 1'b1;
						end else if (!nx_end)
							dith_req <= 1'b1;
					end
					default: st_r <= ST_IDLE;
				endcase
			end
		end
	end

	// Line drivers are registered; a stop releases them next edge.
	always @(posedge aclk) begin
		if (!aresetn) begin
			focus_oen   <= 1'b1;
			shutter_oen <= 1'b1;
		end else begin
			focus_oen   <= !(f_on && !c_stop) || !run;
			shutter_oen <= !(s_on && !c_stop) || !run;
		end
	end

endmodule // css_top

`default_nettype wire

/* testbench/css_sva.sv */
// Purpose: Port-level properties of the camera shutter sequencer.
// Assumes: One clock; reset synchronous and active low.
// Notes:   Attached to css_top by the bind after the module.
`timescale 1ns/1ps
`default_nettype none
`include "css_map.vh"

module css_sva (
	// Clock and reset.
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus.
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Mover and shutter lines.
	input wire logic        dith_req,
	input wire logic        focus_oen,
	input wire logic        shutter_oen
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_write_answer: assert property (
		s_axi_awready |-> s_axi_wready ##1 s_axi_bvalid)
		else $error("write not answered");
	chk_read_answer: assert property (
		s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	chk_ar_once: assert property (
		s_axi_arready |=> !s_axi_arready)
		else $error("read address taken twice");
	chk_refused_zero: assert property (
		s_axi_rvalid && s_axi_rresp == `CSS_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("refused read carries data");
	chk_move_pulse: assert property (
		dith_req |=> !dith_req)
		else $error("move request longer than one cycle");
	chk_stop_release: assert property (
		s_axi_awready && s_axi_awaddr == `CSS_OFS_CTRL && s_axi_wstrb[0]
		&& s_axi_wdata[`CSS_C_STOP] |-> ##[1:3] (focus_oen && shutter_oen))
		else $error("lines still held after stop");
	chk_focus_lead: assert property (
		$fell(focus_oen) && shutter_oen |=> shutter_oen [*8])
		else $error("focus window too short");

	// Main scenarios seen at the ports.
	cov_shot: cover property ($fell(shutter_oen));
	cov_move: cover property (dith_req);
	cov_refuse: cover property (s_axi_bvalid && s_axi_bresp == `CSS_SLVERR);
endmodule // css_sva

bind css_top css_sva u_sva (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.dith_req(dith_req), .focus_oen(focus_oen), .shutter_oen(shutter_oen)
);
`default_nettype wire

/* testbench/css_cam.sv */
// Purpose: Camera remote input that times the shutter lines it sees.
// Assumes: Lines are pulled up; an enable low sinks the line.
// Notes:   Lengths are in clock cycles; a shot is one low run.
`timescale 1ns/1ps
`default_nettype none

module css_cam (
	// Clock.
	input wire logic aclk,
	// Open-collector lines.
	input wire logic focus_oen,
	input wire logic shutter_oen,
	// Observed timing.
	output var int   shots,
	output var int   len_last,
	output var int   len_prev,
	output var int   gap_last,
	output var int   foc_last
);
	int   run, hi, fo;
	logic foc_ln, sht_ln;

	// The pull-up wins whenever the sequencer lets go.
	assign foc_ln = (focus_oen === 1'b0) ? 1'b0 : 1'b1;
	assign sht_ln = (shutter_oen === 1'b0) ? 1'b0 : 1'b1;

	initial begin
		{shots, len_last, len_prev, gap_last, foc_last, run, hi, fo} = '0;
	end

	// A falling shutter line closes the idle gap and its focus lead.
	always @(posedge aclk) begin
		if (!sht_ln) begin
			if (run == 0) begin
				gap_last <= hi;
				foc_last <= fo;
			end
			run <= run + 1;
			hi  <= 0;
			fo  <= 0;
		end else begin
			if (run != 0) begin
				len_prev <= len_last;
				len_last <= run;
				shots    <= shots + 1;
			end
			run <= 0;
			hi  <= hi + 1;
			fo  <= foc_ln ? 0 : fo + 1;
		end
	end
endmodule // css_cam
`default_nettype wire

/* testbench/css_tb.sv */
// Purpose: Self-checking bench of the camera shutter sequencer.
// Assumes: Tick shortened to 20 cycles, so one tick lasts 500 ns here.
// Notes:   Timing checks allow a few cycles of pipeline and bus slack.
`timescale 1ns/1ps
`default_nettype none
`include "css_map.vh"

module tb;
	logic        aclk, aresetn;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic        dith_req, dith_done, dith_busy, focus_oen, shutter_oen;
	int          err_count, checks_done, cyc, mv, nreq, n, s0;
	int          shots, len_last, len_prev, gap_last, foc_last;

	css_top #(.TICK_CYCLES(20)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .dith_req(dith_req), .dith_done(dith_done),
		.dith_busy(dith_busy), .focus_oen(focus_oen),
		.shutter_oen(shutter_oen)
	);
	css_cam cam (
		.aclk(aclk), .focus_oen(focus_oen), .shutter_oen(shutter_oen),
		.shots(shots), .len_last(len_last), .len_prev(len_prev),
		.gap_last(gap_last), .foc_last(foc_last)
	);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Mover: busy for a while after each request, then reports stable.
	always @(posedge aclk) begin
		dith_done <= (mv == 1);
		if (mv != 0) begin
			mv        <= mv - 1;
			dith_busy <= (mv != 1);
		end else if (dith_req === 1'b1) begin
			mv        <= 150;
			dith_busy <= 1'b1;
			nreq      <= nreq + 1;
		end
	end

	// A hang is cut short well past the longest expected run.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	function automatic logic in(input int x, lo, hi);
		return x >= lo && x <= hi;
	endfunction

	function automatic logic [7:0] pa(input int s, p);
		return 8'(`CSS_OFS_PARAM + 16 * s + 4 * p);
	endfunction

	// Write both channels at once and hold until the slave takes them.
	task automatic wx(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'h3;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		while (bvalid !== 1'b1) @(posedge aclk);
		bready <= 1'b0;
		chk("bresp", 32'(er), 32'(bresp));
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask

	task automatic rx(input logic [7:0] a, input logic [31:0] m, e,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk("rresp", 32'(er), 32'(r));
		chk("rdata", e, d & m);
	endtask

	// Poll the status word; the global limit bounds the wait.
	task automatic till(input logic [31:0] m, e);
		logic [31:0] d;
		logic [1:0]  r;
		do rd(`CSS_OFS_STAT, d, r); while ((d & m) !== e);
	endtask

	task automatic prog(input int s, input logic [31:0] sh, wt, ml, ex);
		wx(pa(s, 0), sh, `CSS_OKAY);
		wx(pa(s, 1), wt, `CSS_OKAY);
		wx(pa(s, 2), ml, `CSS_OKAY);
		wx(pa(s, 3), ex, `CSS_OKAY);
	endtask

	task automatic go(input logic [31:0] d);
		s0 = shots;
		wx(`CSS_OFS_CTRL, d, `CSS_OKAY);
	endtask

	task automatic to_shot();
		n = 0;
		while (shutter_oen !== 1'b0) begin
			@(posedge aclk);
			n++;
		end
	endtask

	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, dith_done, dith_busy} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{err_count, checks_done, cyc, mv, nreq, n, s0} = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rx(pa(3, 0), 32'hFFFF, `CSS_RST_SHOTS, `CSS_OKAY);
		rx(pa(3, 1), 32'hFFFF, `CSS_RST_WAIT, `CSS_OKAY);
		rx(pa(3, 2), 32'hFFFF, `CSS_RST_MLU, `CSS_OKAY);
		rx(pa(3, 3), 32'hFFFF, `CSS_RST_EXPO, `CSS_OKAY);
		rx(`CSS_OFS_STAT, 32'hF, 32'h0, `CSS_OKAY);
		rx(8'hFC, 32'hFFFFFFFF, 32'h0, `CSS_SLVERR);
		// Plain run of two shots, no lockup.
		prog(0, 2, 5, 0, 3);
		go(32'h1);
		to_shot();
		chk("first wait", 1, in(n, 196, 206));
		rx(`CSS_OFS_STAT, 32'hF, 32'hF, `CSS_OKAY);
		wx(pa(0, 0), 7, `CSS_SLVERR);
		wx(`CSS_OFS_SLOT, 1, `CSS_SLVERR);
		wx(`CSS_OFS_MODE, 0, `CSS_OKAY);
		till(32'h10, 0);
		chk("shots", 2, shots - s0);
		chk("expo", 1, in(len_last, 59, 61));
		chk("wait", 1, in(gap_last, 99, 103));
		chk("focus", 1, in(foc_last, 58, 62));
		rx(`CSS_OFS_SLOT, 32'h3, 32'h0, `CSS_OKAY);
		// Short lockup stretched to its minimum.
		prog(0, 1, 5, 1, 1);
		go(32'h1);
		till(32'h10, 0);
		chk("pulses", 2, shots - s0);
		chk("flip", 1, in(len_prev, 39, 41));
		chk("lockup", 1, in(gap_last, 59, 61));
		chk("idle focus", 0, foc_last);
		chk("expo", 1, in(len_last, 19, 21));
		// Stop in mid-exposure.
		prog(0, 1, 5, 0, 50);
		go(32'h1);
		to_shot();
		wx(`CSS_OFS_CTRL, 32'h4, `CSS_OKAY);
		@(posedge aclk);
		chk("lines", 32'h3, {30'h0, focus_oen, shutter_oen});
		rx(`CSS_OFS_STAT, 32'h1F, 32'h0, `CSS_OKAY);
		// Pause, edit, continue; then a cancelled pause.
		prog(0, 3, 5, 0, 1);
		go(32'h1);
		to_shot();
		wx(`CSS_OFS_CTRL, 32'h8, `CSS_OKAY);
		rx(`CSS_OFS_STAT, 32'h40, 32'h40, `CSS_OKAY);
		till(32'h20, 32'h20);
		rx(`CSS_OFS_TIME, 32'hFFFF, 32'hA, `CSS_OKAY);
		rx(`CSS_OFS_STAT, 32'h3, 32'h1, `CSS_OKAY);
		wx(pa(0, 3), 2, `CSS_OKAY);
		wx(`CSS_OFS_CTRL, 32'h10, `CSS_OKAY);
		to_shot();
		chk("resume", 1, in(n, 0, 3));
		wx(`CSS_OFS_CTRL, 32'h8, `CSS_OKAY);
		wx(`CSS_OFS_CTRL, 32'h10, `CSS_OKAY);
		till(32'h10, 0);
		chk("shots", 3, shots - s0);
		chk("new expo", 1, in(len_last, 39, 41));
		// Multi run from slot 3: single, all, unused, single.
		wx(`CSS_OFS_SLOT, 3, `CSS_OKAY);
		prog(0, 2, 5, 0, 1);
		prog(1, 1, 5, 0, 1);
		prog(2, 5, 5, 0, 1);
		prog(3, 1, 5, 0, 1);
		wx(`CSS_OFS_MODE, 32'h49, `CSS_OKAY);
		repeat (2) begin
			go(32'h2);
			till(32'h10, 0);
			chk("multi", 4, shots - s0);
		end
		// Dithered run waits for the mover.
		wx(`CSS_OFS_SLOT, 0, `CSS_OKAY);
		go(32'h101);
		s0 = nreq;
		till(32'h10, 0);
		chk("moves", 1, nreq - s0);
		chk("held wait", 1, gap_last >= 250);
		// External timer mode: no multi run, shutter follows the mover.
		wx(`CSS_OFS_CTRL, 32'h300, `CSS_OKAY);
		go(32'h302);
		rx(`CSS_OFS_STAT, 32'h90, 32'h10, `CSS_OKAY);
		till(32'h10, 0);
		chk("ext pulses", 1, shots - s0);
		chk("ext hold", 1, in(len_last, 148, 152));
		print_verdict();
	end
endmodule // tb
`default_nettype wire
